// [hw/adcr_pkg.sv]
package adcr_pkg;
	localparam int unsigned ADDR_W = 13;

	// Register offsets
	localparam logic [12:0] OFS_PORT_SETUP  = 13'h0000;
	localparam logic [12:0] OFS_PART_ID     = 13'h0001;
	localparam logic [12:0] OFS_SPEED_GRADE = 13'h0002;
	localparam logic [12:0] OFS_OP_MODE     = 13'h0008;
	localparam logic [12:0] OFS_COMMIT      = 13'h00FF;
	localparam logic [12:0] OFS_SCRATCH_LO  = 13'h0009;
	localparam logic [12:0] OFS_SCRATCH_HI  = 13'h002A;
	localparam int unsigned SCRATCH_N       = 34;

	// Reset values
	localparam logic [7:0] RST_PORT_SETUP = 8'h18;
	localparam logic [7:0] RST_OP_MODE    = 8'h00;
	localparam logic [7:0] RST_COMMIT     = 8'h00;

	// Port setup fields, nibbles mirrored
	localparam int unsigned POS_LSB_HI  = 6;
	localparam int unsigned POS_SOFT_HI = 5;
	localparam int unsigned POS_SOFT_LO = 2;
	localparam int unsigned POS_LSB_LO  = 1;
	localparam logic [7:0]  PORT_FIXED  = 8'h18;

	// Speed grade field
	localparam int unsigned POS_GRADE = 3;

	// Mode register fields
	localparam int unsigned POS_PIN_FUNCTION = 5;
	localparam logic [7:0]  MODE_MASK        = 8'h27;
	localparam logic [2:0]  MODE_NORMAL      = 3'h0;
	localparam logic [2:0]  MODE_FULL_PD     = 3'h1;
	localparam logic [2:0]  MODE_STANDBY     = 3'h2;
	localparam logic [2:0]  MODE_NORMAL_ALT  = 3'h3;

	// Commit field
	localparam int unsigned POS_COMMIT = 0;

	// Instruction fields
	localparam int unsigned POS_RNW    = 15;
	localparam int unsigned POS_WLEN_HI = 14;
	localparam int unsigned POS_WLEN_LO = 13;
	localparam logic [1:0]  WLEN_STREAM = 2'h3;

	typedef enum logic [1:0] {
		ADCR_PWR_NORMAL,
		ADCR_PWR_FULL_DOWN,
		ADCR_PWR_STANDBY
	} adcr_power_t;

	typedef enum logic [1:0] {
		ADCR_FR_INSTR,
		ADCR_FR_DATA,
		ADCR_FR_DONE
	} adcr_frame_t;
endpackage

// [hw/adcr_serial_frame.sv]
`timescale 1ns/100ps
`default_nettype none
module adcr_serial_frame (
	input  wire logic                        i_core_clk,
	input  wire logic                        i_rst_n,
	input  wire logic                        i_sclk,
	input  wire logic                        i_csb_n,
	input  wire logic                        i_sdio,
	input  wire logic                        i_lsb_first,
	input  wire logic [7:0]                  i_rd_data,
	output logic                             o_sdio,
	output logic                             o_sdio_oe,
	output logic                             o_wr_stb,
	output logic [adcr_pkg::ADDR_W-1:0]      o_addr,
	output logic [adcr_pkg::ADDR_W-1:0]      o_wr_addr,
	output logic [7:0]                       o_wr_data
);
	import adcr_pkg::*;

	typedef struct packed {
		adcr_frame_t         state;
		logic                sclk_q;
		logic                lsb;
		logic                rnw;
		logic                stream;
		logic [1:0]          words;
		logic [3:0]          cnt;
		logic [15:0]         instr;
		logic [7:0]          data;
		logic [ADDR_W-1:0]   addr;
		logic [ADDR_W-1:0]   wr_addr;
		logic                sdio;
		logic                oe;
		logic                wr_stb;
	} adcr_frame_st_t;

	adcr_frame_st_t r;
	adcr_frame_st_t next_r;

	always_comb begin
		logic        rise;
		logic        fall;
		logic [15:0] t_instr;
		logic [7:0]  t_data;
		logic [3:0]  idx16;
		logic [2:0]  idx8;
		rise    = i_sclk & ~r.sclk_q;
		fall    = ~i_sclk & r.sclk_q;
		t_instr = r.instr;
		t_data  = r.data;
		idx16   = r.lsb ? r.cnt : 4'hF - r.cnt;
		idx8    = r.lsb ? r.cnt[2:0] : 3'h7 - r.cnt[2:0];
		next_r  = r;
		next_r.sclk_q = i_sclk;
		next_r.wr_stb = 1'b0;
		if (!i_rst_n) begin
			next_r = '0;
			next_r.state = ADCR_FR_INSTR;
		end else if (i_csb_n) begin
			// Bit order is frozen per frame so a mid-frame change cannot tear it
			next_r.state = ADCR_FR_INSTR;
			next_r.lsb   = i_lsb_first;
			next_r.cnt   = 4'h0;
			next_r.instr = 16'h0000;
			next_r.oe    = 1'b0;
		end else begin
			case (r.state)
				ADCR_FR_INSTR: begin
					if (rise) begin
						t_instr[idx16] = i_sdio;
						next_r.instr   = t_instr;
						next_r.cnt     = r.cnt + 4'h1;
						if (r.cnt == 4'hF) begin
							next_r.state  = ADCR_FR_DATA;
							next_r.cnt    = 4'h0;
							next_r.rnw    = t_instr[POS_RNW];
							next_r.words  = t_instr[POS_WLEN_HI:POS_WLEN_LO];
							next_r.stream = (t_instr[POS_WLEN_HI:POS_WLEN_LO] == WLEN_STREAM);
							next_r.addr   = t_instr[ADDR_W-1:0];
						end
					end
				end
				ADCR_FR_DATA: begin
					if (fall && r.rnw) begin
						next_r.oe   = 1'b1;
						next_r.sdio = i_rd_data[idx8];
					end
					if (rise) begin
						t_data[idx8] = i_sdio;
						next_r.data  = t_data;
						next_r.cnt   = r.cnt + 4'h1;
						if (r.cnt == 4'h7) begin
							next_r.cnt     = 4'h0;
							next_r.wr_stb  = ~r.rnw;
							next_r.wr_addr = r.addr;
							next_r.addr    = r.addr + 13'h0001;
							if (r.words == 2'h0 && !r.stream) begin
								next_r.state = ADCR_FR_DONE;
								next_r.oe    = 1'b0;
							end else if (!r.stream) begin
								next_r.words = r.words - 2'h1;
							end
						end
					end
				end
				ADCR_FR_DONE: begin
					// Surplus clocks after the last word are ignored
					next_r.oe = 1'b0;
				end
				default: begin
					next_r.state = ADCR_FR_INSTR;
				end
			endcase
		end
	end

	always_ff @(posedge i_core_clk) begin
		r <= next_r;
	end

	assign o_sdio    = r.sdio;
	assign o_sdio_oe = r.oe;
	assign o_wr_stb  = r.wr_stb;
	assign o_addr    = r.addr;
	assign o_wr_addr = r.wr_addr;
	assign o_wr_data = r.data;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	AST_FRAME_BIT_ORDER: assert property (
		i_csb_n |=> (r.lsb == $past(i_lsb_first)))
		else $error("frame bit order not taken at frame start");

	AST_NO_DRIVE_OUTSIDE: assert property (
		i_csb_n |=> ##1 !o_sdio_oe)
		else $error("data pin driven while deselected");
endmodule // adcr_serial_frame
`default_nettype wire

// [hw/adcr_regbank.sv]
`timescale 1ns/100ps
`default_nettype none
module adcr_regbank #(
	parameter logic [7:0] PART_ID_CODE = 8'hA5, // Arbitrary value
	parameter logic [1:0] SPEED_CODE   = 2'h0
) (
	input  wire logic            i_core_clk,
	input  wire logic            i_rst_n,
	input  wire logic            i_sclk,
	input  wire logic            i_csb_n,
	input  wire logic            i_sdio,
	output logic                 o_sdio,
	output logic                 o_sdio_oe,
	input  wire logic            i_powerdown_pin,
	output logic [7:0]           o_mode_active,
	output adcr_pkg::adcr_power_t o_power_state,
	output logic                 o_lsb_first
);
	import adcr_pkg::*;

	typedef struct packed {
		logic                        lsb;
		logic [7:0]                  mode_shadow;
		logic [7:0]                  mode_active;
		logic                        commit;
		adcr_power_t                 power;
		logic [SCRATCH_N-1:0][7:0]   scratch;
	} adcr_bank_st_t;

	adcr_bank_st_t r;
	adcr_bank_st_t next_r;

	logic              wr_stb;
	logic [ADDR_W-1:0] rd_addr;
	logic [ADDR_W-1:0] wr_addr;
	logic [7:0]        wr_data;
	logic [7:0]        rd_data;

	adcr_serial_frame u_frame (
		.i_core_clk  (i_core_clk),
		.i_rst_n     (i_rst_n),
		.i_sclk      (i_sclk),
		.i_csb_n     (i_csb_n),
		.i_sdio      (i_sdio),
		.i_lsb_first (r.lsb),
		.i_rd_data   (rd_data),
		.o_sdio      (o_sdio),
		.o_sdio_oe   (o_sdio_oe),
		.o_wr_stb    (wr_stb),
		.o_addr      (rd_addr),
		.o_wr_addr   (wr_addr),
		.o_wr_data   (wr_data)
	);

	// Read decode; unmapped locations read zero
	always_comb begin
		logic [ADDR_W-1:0] sidx;
		sidx    = rd_addr - OFS_SCRATCH_LO;
		rd_data = 8'h00;
		if (rd_addr == OFS_PORT_SETUP) begin
			rd_data = PORT_FIXED;
			rd_data[POS_LSB_HI] = r.lsb;
			rd_data[POS_LSB_LO] = r.lsb;
		end else if (rd_addr == OFS_PART_ID) begin
			rd_data = PART_ID_CODE;
		end else if (rd_addr == OFS_SPEED_GRADE) begin
			rd_data[POS_GRADE+1:POS_GRADE] = SPEED_CODE;
		end else if (rd_addr == OFS_OP_MODE) begin
			rd_data = r.mode_shadow;
		end else if (rd_addr == OFS_COMMIT) begin
			rd_data[POS_COMMIT] = r.commit;
		end else if (rd_addr >= OFS_SCRATCH_LO && rd_addr <= OFS_SCRATCH_HI) begin
			rd_data = r.scratch[sidx[5:0]];
		end
	end

	always_comb begin
		logic [ADDR_W-1:0] widx;
		logic [2:0]        sel;
		widx   = wr_addr - OFS_SCRATCH_LO;
		sel    = 3'h0;
		next_r = r;
		// Copy then clear; a fresh commit write in the same cycle still wins
		if (r.commit) begin
			next_r.mode_active = r.mode_shadow;
			next_r.commit      = 1'b0;
		end
		if (wr_stb) begin
			if (wr_addr == OFS_PORT_SETUP) begin
				// Mirrored nibbles: either copy of a field counts
				next_r.lsb = wr_data[POS_LSB_HI] | wr_data[POS_LSB_LO];
				if (wr_data[POS_SOFT_HI] | wr_data[POS_SOFT_LO]) begin
					next_r.lsb         = RST_PORT_SETUP[POS_LSB_LO];
					next_r.mode_shadow = RST_OP_MODE;
					next_r.mode_active = RST_OP_MODE;
					next_r.commit      = RST_COMMIT[POS_COMMIT];
				end
			end else if (wr_addr == OFS_OP_MODE) begin
				next_r.mode_shadow = wr_data & MODE_MASK;
			end else if (wr_addr == OFS_COMMIT) begin
				if (wr_data[POS_COMMIT]) begin
					next_r.commit = 1'b1;
				end
			end else if (wr_addr >= OFS_SCRATCH_LO && wr_addr <= OFS_SCRATCH_HI) begin
				next_r.scratch[widx[5:0]] = wr_data;
			end
			// Identifier and grade writes fall through untouched
		end
		// Pin overrides the register field
		sel = r.mode_active[2:0];
		if (i_powerdown_pin) begin
			next_r.power = r.mode_active[POS_PIN_FUNCTION] ? ADCR_PWR_STANDBY
			                                               : ADCR_PWR_FULL_DOWN;
		end else if (sel == MODE_FULL_PD) begin
			next_r.power = ADCR_PWR_FULL_DOWN;
		end else if (sel == MODE_STANDBY) begin
			next_r.power = ADCR_PWR_STANDBY;
		end else begin
			next_r.power = ADCR_PWR_NORMAL;
		end
		if (!i_rst_n) begin
			// Scratch bytes are left alone so their contents survive reset
			next_r.lsb         = RST_PORT_SETUP[POS_LSB_LO];
			next_r.mode_shadow = RST_OP_MODE;
			next_r.mode_active = RST_OP_MODE;
			next_r.commit      = RST_COMMIT[POS_COMMIT];
			next_r.power       = ADCR_PWR_NORMAL;
			next_r.scratch     = r.scratch;
		end
	end

	always_ff @(posedge i_core_clk) begin
		r <= next_r;
	end

	assign o_mode_active = r.mode_active;
	assign o_power_state = r.power;
	assign o_lsb_first   = r.lsb;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	sequence seq_commit_write;
		wr_stb && wr_addr == OFS_COMMIT && wr_data[POS_COMMIT];
	endsequence

	sequence seq_commit_done;
		r.commit ##1 !r.commit;
	endsequence

	AST_RESET_DEFAULTS: assert property (@(posedge i_core_clk) disable iff (1'b0)
		!i_rst_n |=> (!r.lsb && r.mode_shadow == RST_OP_MODE && r.mode_active == RST_OP_MODE
		              && !r.commit && !o_lsb_first))
		else $error("defaults not loaded by reset");

	// Armed only on a mid-run reset; scratch bytes are unknown after power-up
	AST_SCRATCH_KEPT: assert property (@(posedge i_core_clk) disable iff (1'b0)
		(!i_rst_n && $past(i_rst_n)) |=> (r.scratch == $past(r.scratch)))
		else $error("scratch bytes changed by reset");

	AST_COMMIT_SELF_CLEAR: assert property (
		seq_commit_write |=> seq_commit_done)
		else $error("commit bit did not clear after one cycle");

	AST_COMMIT_COPY: assert property (
		seq_commit_write ##1 r.commit |=> (o_mode_active == $past(r.mode_shadow)))
		else $error("staged mode not copied on commit");

	AST_ID_READ: assert property (
		rd_addr == OFS_PART_ID |-> rd_data == PART_ID_CODE)
		else $error("identifier altered by write");

	AST_GRADE_READ: assert property (
		rd_addr == OFS_SPEED_GRADE |-> (rd_data[7:5] == 3'h0 && rd_data[2:0] == 3'h0
		                                && rd_data[4:3] == SPEED_CODE))
		else $error("speed grade field wrong");

	AST_POWER_FULL: assert property (
		(!i_powerdown_pin && o_mode_active[2:0] == MODE_FULL_PD) ##1 !i_powerdown_pin
		|-> o_power_state == ADCR_PWR_FULL_DOWN)
		else $error("full power-down not entered");

	AST_PIN_STANDBY: assert property (
		(i_powerdown_pin && o_mode_active[POS_PIN_FUNCTION]) ##1 i_powerdown_pin
		|-> o_power_state == ADCR_PWR_STANDBY)
		else $error("pin standby mapping wrong");

	AST_MODE_STORE: assert property (
		(wr_stb && wr_addr == OFS_OP_MODE) |=> r.mode_shadow == ($past(wr_data) & MODE_MASK))
		else $error("mode write not stored");

	AST_UNMAPPED_ZERO: assert property (
		(rd_addr > OFS_SPEED_GRADE && rd_addr < OFS_OP_MODE) |-> rd_data == 8'h00)
		else $error("gap location not reading zero");

	AST_POWER_STANDBY: assert property (
		(!i_powerdown_pin && o_mode_active[2:0] == MODE_STANDBY) ##1 !i_powerdown_pin
		|-> o_power_state == ADCR_PWR_STANDBY)
		else $error("standby not entered");

	sequence seq_soft_reset;
		wr_stb && wr_addr == OFS_PORT_SETUP && (wr_data[POS_SOFT_HI] || wr_data[POS_SOFT_LO]);
	endsequence

	// Soft bits are not stored, so each write acts only once
	AST_SOFT_RESET: assert property (
		seq_soft_reset |=> (!r.lsb && r.mode_shadow == RST_OP_MODE
		                    && r.mode_active == RST_OP_MODE))
		else $error("soft reset did not load defaults");
endmodule // adcr_regbank
`default_nettype wire

// [test/adcr_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module adcr_host_model (
	input  wire logic i_core_clk,
	input  wire logic i_lsb_mode,
	input  wire logic i_sdio_dev,
	input  wire logic i_sdio_oe,
	output logic      o_sclk,
	output logic      o_csb_n,
	output logic      o_sdio_wire
);
	logic host_oe;
	logic host_d;
	// Pull-up holds the line while nobody drives it
	assign o_sdio_wire = i_sdio_oe ? i_sdio_dev : (host_oe ? host_d : 1'b1);
	initial begin
		o_sclk = 1'b0;
		o_csb_n = 1'b1;
		host_oe = 1'b0;
		host_d = 1'b0;
	end
	// Three core cycles per half keeps well above the sampler's minimum
	task automatic clk_bit(input logic d, input logic drive, output logic q);
		host_oe = drive;
		host_d = d;
		repeat (3) @(negedge i_core_clk);
		q = o_sdio_wire;
		o_sclk = 1'b1;
		repeat (3) @(negedge i_core_clk);
		o_sclk = 1'b0;
	endtask
	task automatic xfer(input logic rnw, input logic [12:0] addr, input int n,
		input logic [15:0] wdata, output logic [15:0] rdata);
		logic [15:0] instr;
		logic q;
		int b;
		int k;
		instr = {rnw, 2'(n - 1), addr};
		rdata = 16'h0000;
		@(negedge i_core_clk);
		o_csb_n = 1'b0;
		for (b = 0; b < 16; b++) begin
			clk_bit(instr[i_lsb_mode ? b : 15 - b], 1'b1, q);
		end
		for (b = 0; b < 8 * n; b++) begin
			k = 8 * (b / 8) + (i_lsb_mode ? b % 8 : 7 - b % 8);
			clk_bit(wdata[k], !rnw, q);
			rdata[k] = q;
		end
		host_oe = 1'b0;
		o_csb_n = 1'b1;
		repeat (4) @(negedge i_core_clk);
	endtask
	// Streaming write: byte j carries base plus j, ended by raising select
	task automatic stream_wr(input logic [12:0] addr, input int n, input logic [7:0] base);
		logic [15:0] instr;
		logic [7:0]  d;
		logic        q;
		int          b;
		instr = {1'b0, 2'h3, addr};
		@(negedge i_core_clk);
		o_csb_n = 1'b0;
		for (b = 0; b < 16; b++) begin
			clk_bit(instr[i_lsb_mode ? b : 15 - b], 1'b1, q);
		end
		for (b = 0; b < 8 * n; b++) begin
			d = base + 8'(b / 8);
			clk_bit(d[i_lsb_mode ? b % 8 : 7 - b % 8], 1'b1, q);
		end
		host_oe = 1'b0;
		o_csb_n = 1'b1;
		repeat (4) @(negedge i_core_clk);
	endtask
endmodule // adcr_host_model
`default_nettype wire

// [test/test_adc_control_register_map.sv]
`timescale 1ns/100ps
`default_nettype none
module test_adc_control_register_map;
	import adcr_pkg::*;
	localparam logic [7:0] ID_CODE = 8'h5A; // Arbitrary value
	localparam logic [1:0] GRADE   = 2'h2;
	typedef struct packed {
		logic        rnw;
		logic [12:0] addr;
		logic [1:0]  n;
		logic [15:0] data;
	} adcr_row_t;
	logic        core_clk, rst_n, sclk, csb_n, sdio, dev_sdio, dev_oe;
	logic        pwr_pin, lsb_first, host_lsb;
	logic [7:0]  mode_active;
	adcr_power_t power_state;
	logic [15:0] rd;
	int          num_errors, checks_done, cycles, m;
	adcr_power_t pst [4] = '{ADCR_PWR_NORMAL, ADCR_PWR_FULL_DOWN, ADCR_PWR_STANDBY,
		ADCR_PWR_NORMAL};
	// Writes keep reserved bits at zero and undefined places at default
	adcr_row_t rows [15] = '{
		'{1'b1, OFS_PORT_SETUP, 2'h1, 16'h0018},
		'{1'b1, OFS_OP_MODE, 2'h1, 16'h0000},
		'{1'b1, OFS_COMMIT, 2'h1, 16'h0000},
		'{1'b1, OFS_PART_ID, 2'h1, {8'h00, ID_CODE}},
		'{1'b0, OFS_PART_ID, 2'h1, 16'h00FF},
		'{1'b1, OFS_PART_ID, 2'h1, {8'h00, ID_CODE}},
		'{1'b1, OFS_SPEED_GRADE, 2'h1, {11'h000, GRADE, 3'h0}},
		'{1'b0, 13'h0005, 2'h1, 16'h0000},
		'{1'b1, 13'h0005, 2'h1, 16'h0000},
		'{1'b0, OFS_SCRATCH_LO, 2'h2, 16'h5AA5},
		'{1'b1, OFS_SCRATCH_LO, 2'h2, 16'h5AA5},
		'{1'b0, OFS_OP_MODE, 2'h1, 16'h0021},
		'{1'b1, OFS_OP_MODE, 2'h1, 16'h0021},
		'{1'b0, OFS_OP_MODE, 2'h1, 16'h0000},
		'{1'b1, OFS_OP_MODE, 2'h1, 16'h0000}
	};
	adcr_regbank #(
		.PART_ID_CODE (ID_CODE),
		.SPEED_CODE   (GRADE)
	) u_adcr_regbank (
		.i_core_clk      (core_clk),
		.i_rst_n         (rst_n),
		.i_sclk          (sclk),
		.i_csb_n         (csb_n),
		.i_sdio          (sdio),
		.o_sdio          (dev_sdio),
		.o_sdio_oe       (dev_oe),
		.i_powerdown_pin (pwr_pin),
		.o_mode_active   (mode_active),
		.o_power_state   (power_state),
		.o_lsb_first     (lsb_first)
	);
	adcr_host_model u_adcr_host_model (
		.i_core_clk  (core_clk),
		.i_lsb_mode  (host_lsb),
		.i_sdio_dev  (dev_sdio),
		.i_sdio_oe   (dev_oe),
		.o_sclk      (sclk),
		.o_csb_n     (csb_n),
		.o_sdio_wire (sdio)
	);
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic wr(input logic [12:0] a, input logic [15:0] d);
		u_adcr_host_model.xfer(1'b0, a, 1, d, rd);
	endtask
	task automatic rd_chk(input logic [12:0] a, input logic [15:0] e);
		u_adcr_host_model.xfer(1'b1, a, 1, 16'h0000, rd);
		check(rd, e);
	endtask
	// Cuts a hang short; the whole run needs under 15000 cycles
	initial begin
		cycles = 0;
		forever begin
			@(posedge core_clk);
			cycles++;
			if (cycles == 30000) begin
				num_errors++;
				finish_test();
			end
		end
	end
	initial begin
		rst_n = 1'b0;
		pwr_pin = 1'b0;
		host_lsb = 1'b0;
		num_errors = 0;
		checks_done = 0;
		repeat (16) @(negedge core_clk);
		check({dev_oe, lsb_first, mode_active}, 16'h0000);
		rst_n = 1'b1;
		repeat (2) @(negedge core_clk);
		// Streamed fill makes every scratch byte known before the mid-run reset
		u_adcr_host_model.stream_wr(OFS_SCRATCH_LO, int'(SCRATCH_N), 8'h40);
		foreach (rows[i]) begin
			u_adcr_host_model.xfer(rows[i].rnw, rows[i].addr, int'(rows[i].n), rows[i].data, rd);
			if (rows[i].rnw === 1'b1) check(rd, rows[i].data);
		end
		for (m = 0; m < 4; m++) begin
			wr(OFS_OP_MODE, 16'(m));
			check(16'(mode_active), 16'(m == 0 ? 0 : m - 1));
			wr(OFS_COMMIT, 16'h0001);
			check(16'(mode_active), 16'(m));
			check(16'(power_state), 16'(pst[m]));
			rd_chk(OFS_COMMIT, 16'h0000);
		end
		// Pin function bit picks full power-down or standby
		for (m = 0; m < 2; m++) begin
			wr(OFS_OP_MODE, 16'(m * 32));
			wr(OFS_COMMIT, 16'h0001);
			pwr_pin = 1'b1;
			repeat (3) @(negedge core_clk);
			check(16'(power_state), 16'(m == 1 ? ADCR_PWR_STANDBY : ADCR_PWR_FULL_DOWN));
			pwr_pin = 1'b0;
			repeat (3) @(negedge core_clk);
			check(16'(power_state), 16'(ADCR_PWR_NORMAL));
		end
		// Mirrored nibbles read the same in either bit order
		wr(OFS_PORT_SETUP, 16'h005A);
		check(16'(lsb_first), 16'h0001);
		host_lsb = 1'b1;
		wr(13'h000B, 16'h0081);
		rd_chk(13'h000B, 16'h0081);
		rd_chk(OFS_PORT_SETUP, 16'h005A);
		wr(OFS_OP_MODE, 16'h0001);
		wr(OFS_COMMIT, 16'h0001);
		check(16'(power_state), 16'(ADCR_PWR_FULL_DOWN));
		rst_n = 1'b0;
		repeat (2) @(negedge core_clk);
		rst_n = 1'b1;
		host_lsb = 1'b0;
		repeat (2) @(negedge core_clk);
		check({lsb_first, mode_active}, 16'h0000);
		check(16'(power_state), 16'(ADCR_PWR_NORMAL));
		rd_chk(OFS_SCRATCH_LO, 16'h00A5);
		rd_chk(13'h000B, 16'h0081);
		rd_chk(OFS_PORT_SETUP, 16'h0018);
		u_adcr_host_model.xfer(1'b1, 13'h0029, 2, 16'h0000, rd);
		check(rd, 16'h6160);
		// Soft reset bits win over the bit-order bits written with them
		wr(OFS_OP_MODE, 16'h0002);
		wr(OFS_COMMIT, 16'h0001);
		check(16'(power_state), 16'(ADCR_PWR_STANDBY));
		wr(OFS_PORT_SETUP, 16'h007E);
		check({lsb_first, mode_active}, 16'h0000);
		check(16'(power_state), 16'(ADCR_PWR_NORMAL));
		rd_chk(OFS_OP_MODE, 16'h0000);
		rd_chk(OFS_PORT_SETUP, 16'h0018);
		finish_test();
	end
endmodule // test_adc_control_register_map
`default_nettype wire
